// >>> axis_model.sv
// axis model: encoder, travel limits, home sensor and marker
`timescale 1ns/10ps
module axis_model
(
    input  logic                   i_clk,
    input  logic                   i_load,
    input  logic [31:0]            i_start_pos,
    input  homing_pkg::motion_type i_motion,
    output logic [31:0]            o_pos,
    output logic                   o_pos_lim,
    output logic                   o_neg_lim,
    output logic                   o_sensor,
    output logic                   o_marker
);
    // one count per cycle while the drive commands motion
    always @(posedge i_clk)
        if (i_load)
            o_pos <= i_start_pos;
        else if (i_motion.run)
            o_pos <= i_motion.forward ? o_pos + 32'h0000_0001 : o_pos - 32'h0000_0001;
    assign o_pos_lim = (o_pos >= 32'h0000_0388);
    assign o_neg_lim = (o_pos <= 32'h0000_0068);
    assign o_sensor  = (o_pos >= 32'h0000_01F8) && (o_pos <= 32'h0000_0258);
    // marker once per 16-count revolution
    assign o_marker  = (o_pos[3:0] == 4'h0);
endmodule : axis_model

// >>> homing_monitor.sv
// assertion checker for the homing sequencer ports
`timescale 1ns/10ps
module homing_monitor
#(
    parameter int POS_WIDTH = 32
)
(
    input logic                   i_clk,
    input logic                   i_reset_n,
    input logic                   i_avs_read,
    input logic                   i_avs_write,
    input logic                   o_avs_waitrequest,
    input logic                   i_positive_travel_limit,
    input homing_pkg::motion_type o_motion,
    input logic [POS_WIDTH-1:0]   o_home_position,
    input logic                   o_home_latched,
    input logic                   o_homing_done,
    input logic                   o_homing_error
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // ****************************************************************
    // properties
    // ****************************************************************
    property p_one_wait;
        (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus access waited too long");
    property p_latch_done;
        o_home_latched |-> o_homing_done && !o_motion.run && !o_homing_error;
    endproperty
    a_latch_done: assert property (p_latch_done) else $error("latch without done");
    property p_latch_once;
        o_home_latched |=> !o_home_latched;
    endproperty
    a_latch_once: assert property (p_latch_once) else $error("latch pulse too long");
    property p_home_hold;
        o_homing_done && !o_home_latched |-> $stable(o_home_position);
    endproperty
    a_home_hold: assert property (p_home_hold) else $error("home moved while done");
    property p_done_sticky;
        o_homing_done && !i_avs_write |=> o_homing_done;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("done dropped");
    property p_error_still;
        o_homing_error && $past(o_homing_error) |-> !o_motion.run && !o_homing_done;
    endproperty
    a_error_still: assert property (p_error_still) else $error("moving in error");
    property p_fast_first;
        $rose(o_motion.run) |-> o_motion.speed_rpm == 16'h0064;
    endproperty
    a_fast_first: assert property (p_fast_first) else $error("first speed wrong");
    property p_speed_set;
        o_motion.run |-> o_motion.speed_rpm inside {16'h0064, 16'h0014};
    endproperty
    a_speed_set: assert property (p_speed_set) else $error("speed not scaled");
    property p_limit_leave;
        $rose(i_positive_travel_limit) && o_motion.run && o_motion.forward |-> ##[1:5]
            (!o_motion.run || !o_motion.forward || o_motion.speed_rpm == 16'h0014);
    endproperty
    a_limit_leave: assert property (p_limit_leave) else $error("limit ignored");
endmodule : homing_monitor

bind servo_homing_sequencer homing_monitor #(.POS_WIDTH(POS_WIDTH)) u_monitor (.*);

// >>> homing_pkg.sv
// package of constants and types for the servo homing sequencer
package homing_pkg;

    // ****************************************************************
    // register map (word byte addresses)
    // ****************************************************************
    localparam logic [3:0] ADDR_CTRL       = 4'h0;
    localparam logic [3:0] ADDR_METHOD     = 4'h4;
    localparam logic [3:0] ADDR_HIGH_SPEED = 4'h8;
    localparam logic [3:0] ADDR_LOW_SPEED  = 4'hC;

    localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

    // control register fields
    localparam int CTRL_START_BIT   = 0;
    localparam int CTRL_ABORT_BIT   = 1;
    localparam int CTRL_PRMODE_BIT  = 2;

    // status fields read back at the control address
    localparam int STAT_BUSY_BIT    = 8;
    localparam int STAT_DONE_BIT    = 9;
    localparam int STAT_ERROR_BIT   = 10;
    localparam int STAT_BADCODE_BIT = 11;

    // ****************************************************************
    // reset values and speed scaling
    // ****************************************************************
    localparam logic [15:0] HIGH_SPEED_RESET = 16'h03E8;
    localparam logic [15:0] LOW_SPEED_RESET  = 16'h00C8;
    localparam logic [5:0]  METHOD_RESET     = 6'h00;
    localparam logic [15:0] SPEED_DIVISOR    = 16'h000A;

    // method codes
    localparam logic [5:0] METHOD_LAST_LIMIT  = 6'h05;
    localparam logic [5:0] METHOD_FIRST_FWD   = 6'h06;
    localparam logic [5:0] METHOD_FIRST_REV   = 6'h0C;
    localparam logic [5:0] METHOD_LAST_SENSOR = 6'h11;
    // positioning-register mode numbering offset; value is arbitrary
    localparam logic [5:0] PR_MODE_OFFSET     = 6'h01;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [6:0]
    {
        ST_IDLE   = 7'b000_0001,
        ST_FAST   = 7'b000_0010,
        ST_MARKER = 7'b000_0100,
        ST_SECOND = 7'b000_1000,
        ST_STOP   = 7'b001_0000,
        ST_DONE   = 7'b010_0000,
        ST_ERROR  = 7'b100_0000
    } state_type;

    typedef enum logic [1:0]
    {
        MK_RETURN = 2'b00,
        MK_ONWARD = 2'b01,
        MK_NONE   = 2'b10
    } marker_type;

    typedef struct packed
    {
        logic        forward;
        logic        use_sensor;
        marker_type  marker;
        logic        reverse_on_limit;
        logic        valid;
    } method_type;

    typedef struct packed
    {
        logic        run;
        logic        forward;
        logic        decel_second;
        logic [15:0] speed_rpm;
    } motion_type;

endpackage : homing_pkg

// >>> servo_homing_sequencer.sv
// homing sequencer for a servo axis with an avalon-mm register slave
//
// The Avalon-MM slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// R1 - with marker configured, after the limit keep seeking the marker and latch there
// R2 - without marker on a limit method, latch home when the limit is seen
// R3 - sequence depends only on the method, never on the start position
// R4 - code 0: forward to positive limit, back to marker, home there
// R5 - code 1: forward to positive limit, on forward to marker, home there
// R6 - code 2: forward to positive limit, home at the limit
// R7 - code 3: reverse to negative limit, back to marker, home there
// R8 - code 4: reverse to negative limit, onward to marker, home there
// R9 - code 5: reverse to negative limit, home at the limit
// R10 - high speed setting is tenths of rpm, 1000 gives 100 rpm
// R11 - low speed setting is tenths of rpm, 200 gives 20 rpm
// R12 - codes 6-11 seek sensor rising edge forward; return, onward, no marker
// R13 - codes 12-17 seek sensor rising edge reverse; return, onward, no marker
// R14 - even sensor codes: a limit during search aborts with an error
// R15 - odd sensor codes: a limit during search reverses the search
// R16 - sensor alone needs a second sensor transition before completion
// R17 - low speed phase may move forward or backward
// R18 - high speed first, low speed second
// R19 - positioning-register mode uses a different code numbering
// R20 - accelerate high, first decel on event, marker at low, second decel stop; the code leaves decel_second clear while a travel limit is active
// R21 - marker pulse comes once per motor revolution
// R22 - done flag set on latch, held until new request or error
// R23 - out-of-range codes rejected, motor stays still
module servo_homing_sequencer
#(
    parameter int POS_WIDTH = 32
)
(
    input  wire logic                   i_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [3:0]             i_avs_address,
    input  wire logic                   i_avs_read,
    input  wire logic                   i_avs_write,
    input  wire logic [31:0]            i_avs_writedata,
    input  wire logic [3:0]             i_avs_byteenable,
    output logic      [31:0]            o_avs_readdata,
    output logic                        o_avs_waitrequest,
    input  wire logic                   i_positive_travel_limit,
    input  wire logic                   i_negative_travel_limit,
    input  wire logic                   i_home_sensor,
    input  wire logic                   i_marker_pulse,
    input  wire logic [POS_WIDTH-1:0]   i_encoder_position,
    output homing_pkg::motion_type      o_motion,
    output logic      [POS_WIDTH-1:0]   o_home_position,
    output logic                        o_home_latched,
    output logic                        o_homing_done,
    output logic                        o_homing_error
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            pin_meta_q <= 4'h0;
            pin_sync_q <= 4'h0;
            pin_prev_q <= 4'h0;
        end
        else
        begin
            pin_meta_q <= {i_marker_pulse, i_home_sensor,
                           i_negative_travel_limit, i_positive_travel_limit};
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    logic pos_limit;
    logic neg_limit;
    logic sensor_rise;
    logic sensor_edge;
    logic marker_rise;

    assign pos_limit   = pin_sync_q[0];
    assign neg_limit   = pin_sync_q[1];
    assign sensor_rise = pin_sync_q[2] & ~pin_prev_q[2];
    assign sensor_edge = pin_sync_q[2] ^ pin_prev_q[2];
    // one marker edge per revolution is taken as one event
    assign marker_rise = pin_sync_q[3] & ~pin_prev_q[3];    // see R21

    // ****************************************************************
    // registers and bus slave
    // ****************************************************************
    logic [5:0]  method_q;
    logic        pr_mode_q;
    logic [15:0] high_speed_q;
    logic [15:0] low_speed_q;
    logic        start_pulse;
    logic        abort_pulse;
    logic        wait_q;
    logic        access;
    homing_pkg::state_type state_q;
    logic        done_q;
    logic        error_q;
    logic        badcode_q;

    assign access            = i_avs_read | i_avs_write;
    // one wait cycle per access, answered on the second edge
    assign o_avs_waitrequest = access & ~wait_q;

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            wait_q <= 1'b0;
        else
            wait_q <= access & ~wait_q;
    end
    logic wr_take;
    logic ctrl_take;
    assign wr_take     = i_avs_write & wait_q;
    assign ctrl_take   = wr_take && i_avs_address == homing_pkg::ADDR_CTRL
                         && i_avs_byteenable[0];
    assign start_pulse = ctrl_take && i_avs_writedata[homing_pkg::CTRL_START_BIT];
    assign abort_pulse = ctrl_take && i_avs_writedata[homing_pkg::CTRL_ABORT_BIT];

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            method_q     <= homing_pkg::METHOD_RESET;
            pr_mode_q    <= 1'b0;
            high_speed_q <= homing_pkg::HIGH_SPEED_RESET;
            low_speed_q  <= homing_pkg::LOW_SPEED_RESET;
        end
        else if (wr_take)
        begin
            case (i_avs_address)
                homing_pkg::ADDR_CTRL:
                    if (i_avs_byteenable[0])
                        pr_mode_q <= i_avs_writedata[homing_pkg::CTRL_PRMODE_BIT];
                homing_pkg::ADDR_METHOD:
                    if (i_avs_byteenable[0])
                        method_q <= i_avs_writedata[5:0];
                homing_pkg::ADDR_HIGH_SPEED:
                begin
                    if (i_avs_byteenable[0])
                        high_speed_q[7:0] <= i_avs_writedata[7:0];
                    if (i_avs_byteenable[1])
                        high_speed_q[15:8] <= i_avs_writedata[15:8];
                end
                homing_pkg::ADDR_LOW_SPEED:
                begin
                    if (i_avs_byteenable[0])
                        low_speed_q[7:0] <= i_avs_writedata[7:0];
                    if (i_avs_byteenable[1])
                        low_speed_q[15:8] <= i_avs_writedata[15:8];
                end
                default: ;
            endcase
        end
    end

    logic [31:0] read_d;
    always_comb
    begin
        read_d = homing_pkg::READ_UNMAPPED;
        case (i_avs_address)
            homing_pkg::ADDR_CTRL:
            begin
                read_d[homing_pkg::CTRL_PRMODE_BIT]  = pr_mode_q;
                read_d[homing_pkg::STAT_BUSY_BIT]    = state_q != homing_pkg::ST_IDLE
                                                       && state_q != homing_pkg::ST_DONE
                                                       && state_q != homing_pkg::ST_ERROR;
                read_d[homing_pkg::STAT_DONE_BIT]    = done_q;
                read_d[homing_pkg::STAT_ERROR_BIT]   = error_q;
                read_d[homing_pkg::STAT_BADCODE_BIT] = badcode_q;
            end
            homing_pkg::ADDR_METHOD:
                read_d[5:0] = method_q;
            homing_pkg::ADDR_HIGH_SPEED:
                read_d[15:0] = high_speed_q;
            homing_pkg::ADDR_LOW_SPEED:
                read_d[15:0] = low_speed_q;
            default:
                read_d = homing_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_avs_readdata <= 32'h0000_0000;
        else if (i_avs_read & ~wait_q)
            o_avs_readdata <= read_d;
    end

    // ****************************************************************
    // method decode
    // ****************************************************************
    function automatic homing_pkg::method_type decode_method(input logic [5:0] raw,
                                                             input logic       pr_mode);
        logic [5:0]             code;
        logic [5:0]             idx;
        homing_pkg::method_type m;
        code               = pr_mode ? raw - homing_pkg::PR_MODE_OFFSET : raw;    // see R19
        m                  = '0;
        m.marker           = homing_pkg::MK_NONE;
        m.valid            = !(pr_mode && raw < homing_pkg::PR_MODE_OFFSET);
        if (code <= homing_pkg::METHOD_LAST_LIMIT)
        begin
            m.forward = code < 6'h03;                                  // see R4 R7
            idx       = m.forward ? code : code - 6'h03;
            m.marker  = homing_pkg::marker_type'(idx[1:0]);            // see R5 R6 R8 R9
        end
        else if (code <= homing_pkg::METHOD_LAST_SENSOR)
        begin
            m.use_sensor       = 1'b1;
            m.forward          = code < homing_pkg::METHOD_FIRST_REV;   // see R12 R13
            idx                = m.forward ? code - homing_pkg::METHOD_FIRST_FWD
                                           : code - homing_pkg::METHOD_FIRST_REV;
            m.marker           = homing_pkg::marker_type'(idx[2:1]);
            m.reverse_on_limit = idx[0];                               // see R14 R15
        end
        else
            m.valid = 1'b0;                                            // see R23
        return m;
    endfunction : decode_method

    homing_pkg::method_type method_q_lat;

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic dir_q;
    logic limit_hit;
    logic limit_ahead;
    assign limit_ahead = dir_q ? pos_limit : neg_limit;
    assign limit_hit   = pos_limit | neg_limit;
    homing_pkg::method_type decoded;
    assign decoded = decode_method(method_q,
                                   ctrl_take ? i_avs_writedata[homing_pkg::CTRL_PRMODE_BIT]
                                             : pr_mode_q);

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state_q      <= homing_pkg::ST_IDLE;
            dir_q        <= 1'b1;
            method_q_lat <= '0;
            badcode_q    <= 1'b0;
        end
        else if (abort_pulse)
            state_q <= homing_pkg::ST_IDLE;
        else if (start_pulse)
        begin
            // every start begins the same way whatever the axis position
            method_q_lat <= decoded;                                   // see R3
            dir_q        <= decoded.forward;
            badcode_q    <= ~decoded.valid;
            state_q      <= decoded.valid ? homing_pkg::ST_FAST
                                          : homing_pkg::ST_IDLE;       // see R23
        end
        else
        begin
            case (state_q)
                homing_pkg::ST_FAST:
                begin
                    if (!method_q_lat.use_sensor && limit_ahead)
                    begin
                        if (method_q_lat.marker == homing_pkg::MK_NONE)
                            state_q <= homing_pkg::ST_STOP;            // see R2
                        else
                            state_q <= homing_pkg::ST_MARKER;          // see R1
                        if (method_q_lat.marker == homing_pkg::MK_RETURN)
                            dir_q <= ~dir_q;
                    end
                    else if (method_q_lat.use_sensor && sensor_rise)
                    begin
                        if (method_q_lat.marker == homing_pkg::MK_NONE)
                            state_q <= homing_pkg::ST_SECOND;          // see R16
                        else
                            state_q <= homing_pkg::ST_MARKER;
                        if (method_q_lat.marker == homing_pkg::MK_RETURN)
                            dir_q <= ~dir_q;                           // see R17
                    end
                    else if (limit_ahead)
                    begin
                        if (method_q_lat.reverse_on_limit)
                            dir_q <= ~dir_q;                           // see R15
                        else
                            state_q <= homing_pkg::ST_ERROR;           // see R14
                    end
                end
                homing_pkg::ST_MARKER:
                begin
                    if (marker_rise)
                        state_q <= homing_pkg::ST_STOP;                // see R1
                    else if (method_q_lat.use_sensor && limit_ahead
                             && !method_q_lat.reverse_on_limit)
                        state_q <= homing_pkg::ST_ERROR;
                end
                homing_pkg::ST_SECOND:
                begin
                    if (sensor_edge)
                        state_q <= homing_pkg::ST_STOP;                // see R16
                    else if (limit_ahead && !method_q_lat.reverse_on_limit)
                        state_q <= homing_pkg::ST_ERROR;
                end
                homing_pkg::ST_STOP:
                    state_q <= homing_pkg::ST_DONE;
                homing_pkg::ST_DONE, homing_pkg::ST_ERROR, homing_pkg::ST_IDLE:
                    state_q <= state_q;
                default:
                    state_q <= homing_pkg::ST_IDLE;
            endcase
        end
    end

    // ****************************************************************
    // home latch and flags
    // ****************************************************************
    logic latch_now;
    assign latch_now = state_q == homing_pkg::ST_STOP;
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_home_position <= '0;
            o_home_latched  <= 1'b0;
        end
        else
        begin
            o_home_latched <= latch_now;
            if (latch_now)
                o_home_position <= i_encoder_position;                 // see R1 R2
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            done_q  <= 1'b0;
            error_q <= 1'b0;
        end
        else
        begin
            if (latch_now)
                done_q <= 1'b1;                                        // see R22
            else if (start_pulse || state_q == homing_pkg::ST_ERROR)
                done_q <= 1'b0;
            if (state_q == homing_pkg::ST_ERROR && !start_pulse)
                error_q <= 1'b1;
            else if (start_pulse)
                error_q <= 1'b0;
        end
    end

    assign o_homing_done  = done_q;
    assign o_homing_error = error_q;

    // ****************************************************************
    // motion command
    // ****************************************************************
    homing_pkg::motion_type motion_d;

    always_comb
    begin
        motion_d              = '0;
        motion_d.forward      = dir_q;
        case (state_q)
            homing_pkg::ST_FAST:
            begin
                motion_d.run       = 1'b1;
                motion_d.speed_rpm = high_speed_q / homing_pkg::SPEED_DIVISOR;  // see R10 R18 R20
            end
            homing_pkg::ST_MARKER, homing_pkg::ST_SECOND:
            begin
                motion_d.run       = 1'b1;
                motion_d.speed_rpm = low_speed_q / homing_pkg::SPEED_DIVISOR;   // see R11 R18 R17
            end
            homing_pkg::ST_STOP:
                motion_d.decel_second = 1'b1;                                  // see R20
            default:
                motion_d.run = 1'b0;
        endcase
        if (limit_hit && !motion_d.run)
            motion_d.decel_second = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_motion <= '0;
        else
            o_motion <= motion_d;
    end

endmodule : servo_homing_sequencer

// >>> tb_top.sv
// self-checking bench for the servo homing sequencer
`timescale 1ns/10ps
module tb_top;
    logic        i_clk = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [3:0]  i_avs_address = 4'h0;
    logic        i_avs_read = 1'b0;
    logic        i_avs_write = 1'b0;
    logic [31:0] i_avs_writedata = 32'h0000_0000;
    logic [3:0]  i_avs_byteenable = 4'hF;
    logic        load = 1'b1;
    logic [31:0] start_pos = 32'h0000_012C;
    logic [31:0] o_avs_readdata, i_encoder_position, o_home_position;
    logic        o_avs_waitrequest, i_positive_travel_limit, i_negative_travel_limit;
    logic        i_home_sensor, i_marker_pulse, o_home_latched, o_homing_done, o_homing_error;
    homing_pkg::motion_type o_motion;
    int          err_count = 0;
    int          checked = 0;
    // limits at 104 and 904, sensor over 504..600, markers every 16 counts
    int tc[21] = '{0, 1, 2, 2, 3, 4, 5, 6, 8, 10, 12, 14, 16, 6, 12, 7, 13, 9, 11, 15, 17};
    int ts[21] = '{300, 300, 300, 800, 300, 300, 300, 300, 300, 300, 700,
                   700, 700, 700, 300, 700, 300, 300, 300, 700, 700};
    int te[21] = '{896, 912, 904, 904, 112, 96, 104, 496, 512, -1, 608,
                   592, -1, -2, -2, -1, -1, -1, -1, -1, -1};

    always #5 i_clk = ~i_clk;

    servo_homing_sequencer #(.POS_WIDTH(32)) u_dut (.*);
    axis_model u_axis (.i_clk(i_clk), .i_load(load), .i_start_pos(start_pos),
        .i_motion(o_motion), .o_pos(i_encoder_position), .o_pos_lim(i_positive_travel_limit),
        .o_neg_lim(i_negative_travel_limit), .o_sensor(i_home_sensor), .o_marker(i_marker_pulse));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic wrap_up(input int hung);
        err_count += hung;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= w;
        i_avs_read <= !w;
        do
            @(posedge i_clk);
        while (o_avs_waitrequest !== 1'b0 && ++n < 50);
        q = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        if (n >= 50)
            wrap_up(1);
    endtask : bus

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask : rchk

    task automatic run_case(input logic pr, input logic [5:0] code, input int start,
                            input int expv);
        logic [31:0] q;
        logic [15:0] last;
        int          n;
        int          d;
        n = 0;
        last = 16'h0000;
        start_pos <= 32'(start);
        load <= 1'b1;
        bus(1'b1, homing_pkg::ADDR_METHOD, 32'(code), q);
        load <= 1'b0;
        bus(1'b1, homing_pkg::ADDR_CTRL, {29'h0000_0000, pr, 2'b01}, q);
        do
            @(negedge i_clk);
        while (o_motion.run !== 1'b1 && ++n < 9);
        chk(32'(o_motion.speed_rpm), 32'h0000_0064);
        chk({30'h0000_0000, o_homing_done, o_homing_error}, 32'h0000_0000);
        while ((o_homing_done | o_homing_error) !== 1'b1 && ++n < 4000)
        begin
            @(negedge i_clk);
            if (o_motion.run === 1'b1)
                last = o_motion.speed_rpm;
        end
        if (n >= 4000)
            wrap_up(1);
        chk(32'(o_homing_error), 32'(expv == -2));
        d = int'(o_home_position) - expv;
        if (expv >= 0)
            chk((d <= 8 && d >= -8) ? 32'(expv) : o_home_position, 32'(expv));
        if (expv >= 0 && expv % 16 == 0)
            chk(32'(last), 32'h0000_0014);
        $display("method %0d from %0d finished", code, start);
    endtask : run_case

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial
    begin
        int          n;
        logic [31:0] q;
        n = 0;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        rchk(homing_pkg::ADDR_CTRL, 32'h0000_0000);
        rchk(homing_pkg::ADDR_METHOD, 32'h0000_0000);
        rchk(homing_pkg::ADDR_HIGH_SPEED, 32'h0000_03E8);
        rchk(homing_pkg::ADDR_LOW_SPEED, 32'h0000_00C8);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF, q);
        rchk(4'h2, 32'h0000_0000);
        $display("register test finished");
        for (int i = 0; i < 21; i++)
            run_case(1'b0, 6'(tc[i]), ts[i], te[i]);
        run_case(1'b1, 6'h03, 300, 904);
        bus(1'b1, homing_pkg::ADDR_METHOD, 32'h0000_0012, q);
        bus(1'b1, homing_pkg::ADDR_CTRL, 32'h0000_0001, q);
        do
            bus(1'b0, homing_pkg::ADDR_CTRL, 32'h0000_0000, q);
        while (q[11] !== 1'b1 && ++n < 9);
        chk({29'h0000_0000, q[11], q[10], q[8]}, 32'h0000_0004);
        chk(32'(o_motion.run), 32'h0000_0000);
        $display("bad code test finished");
        wrap_up(0);
    end
endmodule : tb_top
